// *** hdl/pecir_pkg.sv ***
// constants for the extended control and interrupt register bank
package pecir_pkg;
    // register offsets in the management register space
    localparam logic [4:0] PECIR_ADDR_EXT_CTRL_ONE = 5'h17;
    localparam logic [4:0] PECIR_ADDR_EXT_CTRL_TWO = 5'h18;
    localparam logic [4:0] PECIR_ADDR_IRQ_MASK = 5'h19;
    localparam logic [4:0] PECIR_ADDR_IRQ_STATUS = 5'h1a;

    // extended control one field layout
    localparam int PECIR_RSVD_RW_LSB = 11;
    localparam int PECIR_RSVD_RW_MSB = 15;
    localparam int PECIR_MEDIA_LSB = 8;
    localparam int PECIR_MEDIA_MSB = 10;
    localparam int PECIR_FAR_LOOP_BIT = 3;
    localparam logic [2:0] PECIR_MEDIA_COPPER_ONLY = 3'h0;
    localparam logic [2:0] PECIR_MEDIA_RESET = 3'h0;

    // extended control two field layout
    localparam int PECIR_EDGE_LSB = 13;
    localparam int PECIR_EDGE_MSB = 15;
    localparam int PECIR_REDUCED_PWR_BIT = 12;
    localparam int PECIR_JUMBO_LSB = 4;
    localparam int PECIR_JUMBO_MSB = 5;
    localparam int PECIR_CONN_LOOP_BIT = 0;
    localparam logic [2:0] PECIR_EDGE_RESET = 3'h1;
    localparam logic [2:0] PECIR_EDGE_SLOWEST = 3'h3;
    localparam logic [2:0] PECIR_EDGE_DEFAULT = 3'h6;
    localparam logic [2:0] PECIR_EDGE_FASTEST = 3'h4;
    localparam logic [1:0] PECIR_JUMBO_RESET = 2'h0;
    localparam logic [1:0] PECIR_JUMBO_NORMAL = 2'h0;
    localparam logic [1:0] PECIR_JUMBO_9K = 2'h1;
    localparam logic [1:0] PECIR_JUMBO_12K = 2'h2;

    // maximum packet length in units of 0.5 kB
    localparam logic [5:0] PECIR_LEN_1K5 = 6'h03;
    localparam logic [5:0] PECIR_LEN_9K = 6'h12;
    localparam logic [5:0] PECIR_LEN_12K = 6'h18;
    localparam logic [5:0] PECIR_LEN_16K = 6'h20;

    // interrupt mask and status layout
    localparam int PECIR_IRQ_SUMMARY_BIT = 15;
    localparam int PECIR_CAUSE_SPEED = 14;
    localparam int PECIR_CAUSE_LINK = 13;
    localparam int PECIR_CAUSE_DUPLEX = 12;
    localparam int PECIR_CAUSE_DOWNSHIFT = 2;
    localparam int PECIR_CAUSE_RX_ERR = 0;
    localparam logic [14:0] PECIR_CAUSE_IMPL = 15'h7f6f;
    localparam logic [15:0] PECIR_MASK_IMPL = 16'hff6f;
    localparam logic [15:0] PECIR_MASK_RESET = 16'h0000;
    localparam logic [3:0] PECIR_ADV_ALL = 4'hf;
endpackage : pecir_pkg

// *** hdl/pecir_cause_latch.sv ***
// sticky pending-cause word with read-to-clear and summary bit
`timescale 1ns/1ns
module pecir_cause_latch
    import pecir_pkg::*;
#(
    parameter int CAUSES = 15
)
(
    input wire logic i_mclk,                    // core clock
    input wire logic i_resetn,                  // synchronous reset, active low
    input wire logic i_sw_reset,                // software reset pulse
    input wire logic [CAUSES-1:0] i_set,        // qualified cause pulses
    input wire logic [CAUSES-1:0] i_enable,     // cause mask bits
    input wire logic i_read_clear,              // status word read pulse
    output logic [CAUSES-1:0] o_cause,          // pending causes
    output logic o_summary                      // any enabled cause pending
);
    // the cause map is fixed, so any other width is refused at elaboration
    if (CAUSES != 15)
    begin : g_bad_causes
        $error("pecir_cause_latch: CAUSES must be 15");
    end

    logic [CAUSES-1:0] next_cause;
    logic next_summary;
    logic [CAUSES-1:0] new_enabled;

    // a set arriving with the read is kept, since the host never saw it
    always_comb
    begin
        new_enabled = i_set & i_enable;
        if (i_read_clear)
        begin
            next_cause = i_set;
            next_summary = |new_enabled;
        end
        else
        begin
            next_cause = o_cause | i_set;
            next_summary = o_summary | (|new_enabled);
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_resetn || i_sw_reset)
        begin
            o_cause <= '0;
            o_summary <= 1'b0;
        end
        else
        begin
            o_cause <= next_cause & PECIR_CAUSE_IMPL;
            o_summary <= next_summary;
        end
    end
endmodule : pecir_cause_latch

// *** hdl/pecir_regs.sv ***
// extended control, interrupt mask and interrupt status register bank of one port
// How it works
// - media mode field, super-sticky, resets copper-only
// - new media mode waits for software reset
// - media field reads back mode in effect
// - sticky edge rate field, default 001
// - sticky jumbo field selects packet length
// - longer jumbo limits need reference clock within 60 ppm (9K mode) or 70 ppm (12K mode)
// - sticky mask bits, reserved bits read zero
// - pin enable routes summary bit to pin
// - pin enable off still records status
// - status bits report the fixed cause list
// - reading status clears every bit set before the read
// - bit 15 summarises, low bits give cause
// - speed and duplex causes need autonegotiation
// - downshift cause needs all four advertisement bits
// - no receive error during carrier extension
// - sticky bits kept only when retention enabled
// - autonegotiation disabled is inverse of enable
`timescale 1ns/1ns
module pecir_regs
    import pecir_pkg::*;
#(
    parameter int ADDR_W = 5,
    parameter int DATA_W = 16
)
(
    input wire logic i_mclk,                    // core clock, 25 MHz
    input wire logic i_resetn,                  // synchronous reset, active low
    input wire logic [ADDR_W-1:0] i_reg_addr,   // register address
    input wire logic i_reg_wr,                  // write strobe, one cycle
    input wire logic i_reg_rd,                  // read strobe, one cycle
    input wire logic [DATA_W-1:0] i_reg_wdata,  // write data
    input wire logic i_sw_reset,                // software reset pulse, register 0 bit 15
    input wire logic i_sticky_keep,             // sticky retention enable, bit 22.9
    input wire logic i_aneg_enable,             // autonegotiation enable, bit 0.12
    input wire logic [3:0] i_adv_bits,          // advertisement bits 4.8:5
    input wire logic i_carrier_ext,             // receive error used for carrier extension
    input wire logic i_ref_60ppm,               // reference clock held within 60 ppm
    input wire logic i_ref_70ppm,               // reference clock held within 70 ppm
    input wire logic [14:0] i_event,            // raw event pulses, one per cause
    output logic [DATA_W-1:0] o_reg_rdata,      // read data, registered
    output logic o_reg_rvalid,                  // read data valid pulse
    output logic [2:0] o_media_mode,            // media mode in effect
    output logic o_far_end_loopback,            // far-end loopback enable
    output logic o_connector_loopback,          // connector loopback enable
    output logic [2:0] o_edge_rate,             // 100BASE-TX edge rate code
    output logic o_reduced_power,               // reduced power mode enable
    output logic [1:0] o_jumbo_mode,            // jumbo packet mode code
    output logic [5:0] o_max_pkt_len,           // max packet length, 0.5 kB units
    output logic o_aneg_disabled,               // autonegotiation disabled indication
    output logic o_mgmt_irq_pin_out,            // interrupt pin level when driven
    output logic o_mgmt_irq_pin_oe              // interrupt pin open-drain enable
);
    // one field map is wired in, so other widths are refused at elaboration
    if (ADDR_W != 5 || DATA_W != 16)
    begin : g_bad_width
        $error("pecir_regs: only a 5-bit address and 16-bit data are served");
    end

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [4:0] target);
        hit = (a == target);
    endfunction : hit

    logic [4:0] rsvd_rw;
    logic [2:0] media_pending;
    logic [2:0] media_active;
    logic far_loop;
    logic conn_loop;
    logic [2:0] edge_rate;
    logic reduced_pwr;
    logic [1:0] jumbo;
    logic [15:0] irq_mask;
    logic [14:0] cause;
    logic summary;
    logic [14:0] qualified;
    logic status_read;
    logic wr_one;
    logic wr_two;
    logic wr_mask;
    logic sticky_clear;
    logic [DATA_W-1:0] next_rdata;
    logic [5:0] next_len;

    assign wr_one = i_reg_wr && hit(i_reg_addr, PECIR_ADDR_EXT_CTRL_ONE);
    assign wr_two = i_reg_wr && hit(i_reg_addr, PECIR_ADDR_EXT_CTRL_TWO);
    assign wr_mask = i_reg_wr && hit(i_reg_addr, PECIR_ADDR_IRQ_MASK);
    assign status_read = i_reg_rd && hit(i_reg_addr, PECIR_ADDR_IRQ_STATUS);
    // software reset wipes sticky fields only when retention is off
    assign sticky_clear = i_sw_reset && !i_sticky_keep;

    // super-sticky: software reset only applies the pending mode, never clears
    always_ff @(posedge i_mclk)
    begin
        if (!i_resetn)
        begin
            media_pending <= PECIR_MEDIA_RESET;
            media_active <= PECIR_MEDIA_RESET;
        end
        else
        begin
            if (wr_one)
                media_pending <= i_reg_wdata[PECIR_MEDIA_MSB:PECIR_MEDIA_LSB];
            // a write in the reset cycle itself is applied at once
            if (i_sw_reset)
                media_active <= wr_one ? i_reg_wdata[PECIR_MEDIA_MSB:PECIR_MEDIA_LSB]
                                       : media_pending;
        end
    end

    // plain control bits return to defaults on any software reset
    always_ff @(posedge i_mclk)
    begin
        if (!i_resetn || i_sw_reset)
        begin
            rsvd_rw <= 5'h00;
            far_loop <= 1'b0;
            conn_loop <= 1'b0;
        end
        else
        begin
            if (wr_one)
            begin
                rsvd_rw <= i_reg_wdata[PECIR_RSVD_RW_MSB:PECIR_RSVD_RW_LSB];
                far_loop <= i_reg_wdata[PECIR_FAR_LOOP_BIT];
            end
            if (wr_two)
                conn_loop <= i_reg_wdata[PECIR_CONN_LOOP_BIT];
        end
    end

    // sticky control fields of register two
    always_ff @(posedge i_mclk)
    begin
        if (!i_resetn || sticky_clear)
        begin
            edge_rate <= PECIR_EDGE_RESET;
            reduced_pwr <= 1'b0;
            jumbo <= PECIR_JUMBO_RESET;
        end
        else if (wr_two)
        begin
            edge_rate <= i_reg_wdata[PECIR_EDGE_MSB:PECIR_EDGE_LSB];
            reduced_pwr <= i_reg_wdata[PECIR_REDUCED_PWR_BIT];
            jumbo <= i_reg_wdata[PECIR_JUMBO_MSB:PECIR_JUMBO_LSB];
        end
    end

    // sticky mask word
    always_ff @(posedge i_mclk)
    begin
        if (!i_resetn || sticky_clear)
            irq_mask <= PECIR_MASK_RESET;
        else if (wr_mask)
            irq_mask <= i_reg_wdata & PECIR_MASK_IMPL;
    end

    // cause qualification before latching
    always_comb
    begin
        qualified = i_event;
        qualified[PECIR_CAUSE_SPEED] = i_event[PECIR_CAUSE_SPEED] && i_aneg_enable;
        qualified[PECIR_CAUSE_DUPLEX] = i_event[PECIR_CAUSE_DUPLEX] && i_aneg_enable;
        qualified[PECIR_CAUSE_DOWNSHIFT] = i_event[PECIR_CAUSE_DOWNSHIFT]
                                           && (i_adv_bits == PECIR_ADV_ALL);
        qualified[PECIR_CAUSE_RX_ERR] = i_event[PECIR_CAUSE_RX_ERR] && !i_carrier_ext;
    end

    pecir_cause_latch #(
        .CAUSES(15)
    ) u_cause (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_sw_reset(i_sw_reset),
        .i_set(qualified),
        .i_enable(irq_mask[14:0]),
        .i_read_clear(status_read),
        .o_cause(cause),
        .o_summary(summary)
    );

    // jumbo limit; 9K mode lengthens with the 60 ppm clock, 12K mode with the 70 ppm clock
    always_comb
    begin
        case (jumbo)
            PECIR_JUMBO_NORMAL: next_len = PECIR_LEN_1K5;
            PECIR_JUMBO_9K: next_len = i_ref_60ppm ? PECIR_LEN_12K : PECIR_LEN_9K;
            PECIR_JUMBO_12K: next_len = i_ref_70ppm ? PECIR_LEN_16K : PECIR_LEN_12K;
            default: next_len = PECIR_LEN_1K5;
        endcase
    end

    // read mux; status read returns the word as it was before clearing
    always_comb
    begin
        next_rdata = '0;
        case (i_reg_addr)
            PECIR_ADDR_EXT_CTRL_ONE:
            begin
                next_rdata[PECIR_RSVD_RW_MSB:PECIR_RSVD_RW_LSB] = rsvd_rw;
                next_rdata[PECIR_MEDIA_MSB:PECIR_MEDIA_LSB] = media_active;
                next_rdata[PECIR_FAR_LOOP_BIT] = far_loop;
            end
            PECIR_ADDR_EXT_CTRL_TWO:
            begin
                next_rdata[PECIR_EDGE_MSB:PECIR_EDGE_LSB] = edge_rate;
                next_rdata[PECIR_REDUCED_PWR_BIT] = reduced_pwr;
                next_rdata[PECIR_JUMBO_MSB:PECIR_JUMBO_LSB] = jumbo;
                next_rdata[PECIR_CONN_LOOP_BIT] = conn_loop;
            end
            PECIR_ADDR_IRQ_MASK: next_rdata = irq_mask;
            PECIR_ADDR_IRQ_STATUS: next_rdata = {summary, cause};
            default: next_rdata = '0;
        endcase
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_resetn)
        begin
            o_reg_rdata <= '0;
            o_reg_rvalid <= 1'b0;
        end
        else
        begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd)
                o_reg_rdata <= next_rdata;
        end
    end

    // control outputs, one flop behind the register state
    always_ff @(posedge i_mclk)
    begin
        if (!i_resetn)
        begin
            o_media_mode <= PECIR_MEDIA_RESET;
            o_far_end_loopback <= 1'b0;
            o_connector_loopback <= 1'b0;
            o_edge_rate <= PECIR_EDGE_RESET;
            o_reduced_power <= 1'b0;
            o_jumbo_mode <= PECIR_JUMBO_RESET;
            o_max_pkt_len <= PECIR_LEN_1K5;
            o_aneg_disabled <= 1'b0;
        end
        else
        begin
            o_media_mode <= media_active;
            o_far_end_loopback <= far_loop;
            o_connector_loopback <= conn_loop;
            o_edge_rate <= edge_rate;
            o_reduced_power <= reduced_pwr;
            o_jumbo_mode <= jumbo;
            o_max_pkt_len <= next_len;
            o_aneg_disabled <= !i_aneg_enable;
        end
    end

    // open drain: pulled low while enabled summary is pending
    always_ff @(posedge i_mclk)
    begin
        if (!i_resetn)
        begin
            o_mgmt_irq_pin_out <= 1'b0;
            o_mgmt_irq_pin_oe <= 1'b0;
        end
        else
        begin
            o_mgmt_irq_pin_out <= 1'b0;
            o_mgmt_irq_pin_oe <= irq_mask[PECIR_IRQ_SUMMARY_BIT] && summary;
        end
    end
endmodule : pecir_regs

// *** bench/pecir_host.sv ***
// station management host model driving the register strobes
`timescale 1ns/1ns
module pecir_host
    import pecir_pkg::*;
(
    input wire logic i_mclk, // core clock
    input wire logic [15:0] i_reg_rdata, // read data
    input wire logic i_reg_rvalid, // read data valid
    output logic [4:0] o_reg_addr, // register address
    output logic o_reg_wr, // write strobe
    output logic o_reg_rd, // read strobe
    output logic [15:0] o_reg_wdata, // write data
    output logic o_sw_reset // software reset pulse
);
    initial
    begin
        o_reg_addr = 5'h00;
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_wdata = 16'h0000;
        o_sw_reset = 1'b0;
    end

    // released lines show the inverse so a stale value is never mistaken for a live one
    task wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge i_mclk);
        o_reg_addr <= a;
        o_reg_wdata <= v;
        o_reg_wr <= 1'b1;
        @(posedge i_mclk);
        o_reg_wr <= 1'b0;
        o_reg_addr <= ~a;
        o_reg_wdata <= ~v;
    endtask : wr

    task rd(input logic [4:0] a, input int n, output logic [15:0] v);
        @(posedge i_mclk);
        o_reg_addr <= a;
        o_reg_rd <= 1'b1;
        repeat (n) @(posedge i_mclk);
        o_reg_rd <= 1'b0;
        o_reg_addr <= ~a;
        #1;
        v = i_reg_rvalid ? i_reg_rdata : 16'hdead;
    endtask : rd

    task sw_rst;
        @(posedge i_mclk);
        o_sw_reset <= 1'b1;
        @(posedge i_mclk);
        o_sw_reset <= 1'b0;
    endtask : sw_rst

    task pin_on(input logic [15:0] m);
        logic [15:0] v;
        rd(PECIR_ADDR_IRQ_STATUS, 1, v);
        wr(PECIR_ADDR_IRQ_MASK, m);
    endtask : pin_on
endmodule : pecir_host

// *** bench/pecir_regs_sva.sv ***
// port assertions for the extended control and interrupt register bank
`timescale 1ns/1ns
module pecir_regs_sva
    import pecir_pkg::*;
(
    input wire logic i_mclk, // core clock
    input wire logic i_resetn, // reset, active low
    input wire logic [4:0] i_reg_addr, // address
    input wire logic i_reg_wr, // write strobe
    input wire logic i_reg_rd, // read strobe
    input wire logic [15:0] i_reg_wdata, // write data
    input wire logic i_sw_reset, // software reset
    input wire logic i_aneg_enable, // autoneg enable
    input wire logic i_ref_60ppm, // tight reference
    input wire logic [14:0] i_event, // raw events
    input wire logic [15:0] o_reg_rdata, // read data
    input wire logic o_reg_rvalid, // read valid
    input wire logic [2:0] o_media_mode, // media mode
    input wire logic o_connector_loopback, // loopback
    input wire logic [2:0] o_edge_rate, // edge rate
    input wire logic o_reduced_power, // reduced power
    input wire logic [1:0] o_jumbo_mode, // jumbo code
    input wire logic [5:0] o_max_pkt_len, // max length
    input wire logic o_aneg_disabled, // autoneg off
    input wire logic o_mgmt_irq_pin_out, // pin level
    input wire logic o_mgmt_irq_pin_oe // pin enable
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_resetn);

    wire st_rd = i_reg_rd && i_reg_addr == PECIR_ADDR_IRQ_STATUS;
    wire mk_rd = i_reg_rd && i_reg_addr == PECIR_ADDR_IRQ_MASK;
    wire [6:0] ctl2 = {i_reg_wdata[15:12], i_reg_wdata[5:4], i_reg_wdata[0]};

    property p_pin_low;
        o_mgmt_irq_pin_out == 1'b0;
    endproperty
    a_pin_low: assert property (p_pin_low) else $error("pin drives high");
    // an event in the first read cycle survives, so any pair whose first read is quiet must read zero
    property p_stat_clear;
        st_rd && i_event == 15'h0 ##1 st_rd |=> o_reg_rdata == 16'h0;
    endproperty
    a_stat_clear: assert property (p_stat_clear) else $error("status not cleared");
    property p_stat_rsvd;
        o_reg_rvalid && $past(st_rd) |-> o_reg_rdata[7] == 1'b0 && o_reg_rdata[4] == 1'b0;
    endproperty
    a_stat_rsvd: assert property (p_stat_rsvd) else $error("status reserved set");
    property p_mask_rsvd;
        o_reg_rvalid && $past(mk_rd) |-> o_reg_rdata[7] == 1'b0 && o_reg_rdata[4] == 1'b0;
    endproperty
    a_mask_rsvd: assert property (p_mask_rsvd) else $error("mask reserved set");
    property p_pin_rel;
        $fell(o_mgmt_irq_pin_oe) |-> $past(st_rd, 2) || $past(i_reg_wr, 2) || $past(i_sw_reset, 2);
    endproperty
    a_pin_rel: assert property (p_pin_rel) else $error("pin released early");
    property p_ctl_two;
        i_reg_wr && i_reg_addr == PECIR_ADDR_EXT_CTRL_TWO ##1 !i_sw_reset && !i_reg_wr
        |=> {o_edge_rate, o_reduced_power, o_jumbo_mode, o_connector_loopback} == $past(ctl2, 2);
    endproperty
    a_ctl_two: assert property (p_ctl_two) else $error("control two mismatch");
    property p_media;
        $changed(o_media_mode) |-> $past(i_sw_reset, 2);
    endproperty
    a_media: assert property (p_media) else $error("media changed early");
    property p_aneg;
        $past(i_resetn) |-> o_aneg_disabled == !$past(i_aneg_enable);
    endproperty
    a_aneg: assert property (p_aneg) else $error("autoneg flag wrong");
    property p_jumbo;
        o_jumbo_mode == PECIR_JUMBO_9K && $stable(o_jumbo_mode) && !i_ref_60ppm && $stable(i_ref_60ppm)
        |-> o_max_pkt_len == PECIR_LEN_9K;
    endproperty
    a_jumbo: assert property (p_jumbo) else $error("jumbo length wrong");
endmodule : pecir_regs_sva

bind pecir_regs pecir_regs_sva chk_i (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .i_sw_reset(i_sw_reset),
    .i_aneg_enable(i_aneg_enable), .i_ref_60ppm(i_ref_60ppm), .i_event(i_event), .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid), .o_media_mode(o_media_mode), .o_connector_loopback(o_connector_loopback),
    .o_edge_rate(o_edge_rate), .o_reduced_power(o_reduced_power), .o_jumbo_mode(o_jumbo_mode),
    .o_max_pkt_len(o_max_pkt_len), .o_aneg_disabled(o_aneg_disabled),
    .o_mgmt_irq_pin_out(o_mgmt_irq_pin_out), .o_mgmt_irq_pin_oe(o_mgmt_irq_pin_oe));

// *** bench/phy_ext_control_irq_regs_test.sv ***
// self-checking bench for the extended control and interrupt register bank
`timescale 1ns/1ns
module phy_ext_control_irq_regs_test
    import pecir_pkg::*;
;
    logic i_mclk, i_resetn, i_reg_wr, i_reg_rd, i_sw_reset, i_sticky_keep, i_aneg_enable;
    logic i_carrier_ext, i_ref_60ppm, i_ref_70ppm, o_reg_rvalid, o_far_end_loopback;
    logic o_connector_loopback, o_reduced_power, o_aneg_disabled, o_mgmt_irq_pin_out, o_mgmt_irq_pin_oe;
    logic [4:0] i_reg_addr;
    logic [15:0] i_reg_wdata, o_reg_rdata, d;
    logic [3:0] i_adv_bits;
    logic [14:0] i_event;
    logic [2:0] o_media_mode, o_edge_rate;
    logic [1:0] o_jumbo_mode;
    logic [5:0] o_max_pkt_len;
    int n_mismatch, n_tests;
    // open-drain pin with pull-up
    wire pin = o_mgmt_irq_pin_oe ? 1'b0 : 1'b1;

    pecir_regs uut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .i_sw_reset(i_sw_reset), .i_sticky_keep(i_sticky_keep),
        .i_aneg_enable(i_aneg_enable), .i_adv_bits(i_adv_bits), .i_carrier_ext(i_carrier_ext),
        .i_ref_60ppm(i_ref_60ppm), .i_ref_70ppm(i_ref_70ppm), .i_event(i_event), .o_reg_rdata(o_reg_rdata),
        .o_reg_rvalid(o_reg_rvalid), .o_media_mode(o_media_mode), .o_far_end_loopback(o_far_end_loopback),
        .o_connector_loopback(o_connector_loopback), .o_edge_rate(o_edge_rate),
        .o_reduced_power(o_reduced_power), .o_jumbo_mode(o_jumbo_mode), .o_max_pkt_len(o_max_pkt_len),
        .o_aneg_disabled(o_aneg_disabled), .o_mgmt_irq_pin_out(o_mgmt_irq_pin_out),
        .o_mgmt_irq_pin_oe(o_mgmt_irq_pin_oe));
    pecir_host host (.i_mclk(i_mclk), .i_reg_rdata(o_reg_rdata), .i_reg_rvalid(o_reg_rvalid),
        .o_reg_addr(i_reg_addr), .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd), .o_reg_wdata(i_reg_wdata),
        .o_sw_reset(i_sw_reset));

    initial
    begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end

    task end_of_test;
        if (n_mismatch == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task cyc(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask : cyc

    task ev_chk(input logic [14:0] v, input logic p, input logic [15:0] e);
        @(posedge i_mclk);
        i_event <= v;
        @(posedge i_mclk);
        i_event <= 15'h0;
        cyc(2);
        chk(16'(pin), 16'(p));
        host.rd(PECIR_ADDR_IRQ_STATUS, 1, d);
        chk(d, e);
    endtask : ev_chk

    task jchk(input logic [1:0] c, input logic p6, input logic p7, input logic [5:0] len);
        @(posedge i_mclk);
        i_ref_60ppm <= p6;
        i_ref_70ppm <= p7;
        host.wr(PECIR_ADDR_EXT_CTRL_TWO, {10'h0, c, 4'h0});
        cyc(3);
        chk(16'(o_max_pkt_len), 16'(len));
    endtask : jchk

    task t_defaults;
        host.rd(PECIR_ADDR_EXT_CTRL_ONE, 1, d);
        chk(d, 16'h0000);
        host.rd(PECIR_ADDR_EXT_CTRL_TWO, 1, d);
        chk(d, 16'h2000);
        host.rd(PECIR_ADDR_IRQ_MASK, 1, d);
        chk(d, 16'h0000);
        host.rd(5'h1b, 1, d);
        chk(d, 16'h0000);
        chk(16'(o_max_pkt_len), 16'h0003);
    endtask : t_defaults

    task t_media;
        host.wr(PECIR_ADDR_EXT_CTRL_ONE, 16'hf708);
        host.rd(PECIR_ADDR_EXT_CTRL_ONE, 1, d);
        chk(d, 16'hf008);
        chk(16'(o_far_end_loopback), 16'h0001);
        host.sw_rst();
        host.rd(PECIR_ADDR_EXT_CTRL_ONE, 1, d);
        chk(d, 16'h0700);
        cyc(1);
        chk(16'(o_media_mode), 16'h0007);
    endtask : t_media

    task t_ctl2;
        for (int i = 0; i < 8; i++)
        begin
            host.wr(PECIR_ADDR_EXT_CTRL_TWO, {i[2:0], 13'h1fff});
            host.rd(PECIR_ADDR_EXT_CTRL_TWO, 1, d);
            chk(d, {i[2:0], 13'h1031});
            chk(16'(o_edge_rate), 16'(i[2:0]));
        end
        host.sw_rst();
        host.rd(PECIR_ADDR_EXT_CTRL_TWO, 1, d);
        chk(d, 16'hf030);
        @(posedge i_mclk);
        i_sticky_keep <= 1'b0;
        host.sw_rst();
        host.rd(PECIR_ADDR_EXT_CTRL_TWO, 1, d);
        chk(d, 16'h2000);
        host.rd(PECIR_ADDR_EXT_CTRL_ONE, 1, d);
        chk(d, 16'h0700);
        jchk(2'h1, 1'b0, 1'b0, 6'h12);
        jchk(2'h1, 1'b1, 1'b0, 6'h18);
        jchk(2'h2, 1'b1, 1'b0, 6'h18);
        jchk(2'h2, 1'b1, 1'b1, 6'h20);
        jchk(2'h3, 1'b0, 1'b0, 6'h03);
    endtask : t_ctl2

    task t_irq;
        host.wr(PECIR_ADDR_IRQ_MASK, 16'h7fff);
        host.rd(PECIR_ADDR_IRQ_MASK, 1, d);
        chk(d, 16'h7f6f);
        ev_chk(15'h0002, 1'b1, 16'h8002);
        host.pin_on(16'h8000);
        ev_chk(15'h0002, 1'b1, 16'h0002);
        host.pin_on(16'hffff);
        ev_chk(15'h2000, 1'b0, 16'ha000);
        cyc(2);
        chk(16'(pin), 16'h0001);
        host.rd(PECIR_ADDR_IRQ_STATUS, 2, d);
        chk(d, 16'h0000);
        ev_chk(15'h7fff, 1'b0, 16'hff6f);
        @(posedge i_mclk);
        i_aneg_enable <= 1'b0;
        i_adv_bits <= 4'h7;
        i_carrier_ext <= 1'b1;
        ev_chk(15'h5000, 1'b1, 16'h0000);
        ev_chk(15'h0004, 1'b1, 16'h0000);
        ev_chk(15'h0001, 1'b1, 16'h0000);
        chk(16'(o_aneg_disabled), 16'h0001);
    endtask : t_irq

    initial
    begin
        i_resetn = 1'b0;
        i_sticky_keep = 1'b1;
        i_aneg_enable = 1'b1;
        i_adv_bits = 4'hf;
        i_carrier_ext = 1'b0;
        i_ref_60ppm = 1'b0;
        i_ref_70ppm = 1'b0;
        i_event = 15'h0;
        repeat (5) @(posedge i_mclk);
        i_resetn <= 1'b1;
        t_defaults();
        t_media();
        t_ctl2();
        t_irq();
        end_of_test();
    end

    // about 160 cycles are needed; a hang is cut well beyond that
    initial
    begin
        repeat (4000) @(posedge i_mclk);
        n_mismatch++;
        end_of_test();
    end
endmodule : phy_ext_control_irq_regs_test
